// *** csw_status_word.v ***
// device status word: flag register, command receiver and normal reply sender
// assumes card_clk and cmd_in come from the host side, the rest from card logic on clk
`timescale 1ns/1ps
`include "csw_regs.vh"

module csw_status_word (
    // clock and reset
    input wire clk,
    input wire rst,
    // card command bus
    input wire card_clk,
    input wire cmd_in,
    output wire cmd_out,
    output wire cmd_oe,
    // accepted command towards card logic
    output wire cmd_valid,
    output wire [5:0] cmd_index,
    output wire [31:0] cmd_arg,
    // error events from card logic, one-cycle pulses
    input wire arg_bounds_err_set,
    input wire addr_misalign_err_set,
    input wire blk_size_err_set,
    input wire erase_order_err_set,
    input wire erase_selection_err_set,
    input wire protected_write_err_set,
    input wire lock_fail_err_set,
    input wire cmd_not_allowed_err_set,
    input wire ecc_fail_err_set,
    input wire controller_internal_err_set,
    input wire general_err_set,
    input wire spec_data_overwrite_err_set,
    input wire erase_skip_err_set,
    // present card condition
    input wire locked_flag,
    input wire [`CSW_LOW_BITS-1:0] lower_status,
    // last word sent
    output wire [31:0] device_status_word
);

    localparam ST_IDLE = 3'h0;
    localparam ST_RECV = 3'h1;
    localparam ST_CHECK = 3'h2;
    localparam ST_EVAL = 3'h3;
    localparam ST_GAP = 3'h4;
    localparam ST_SEND = 3'h5;

    // synchronisers for the bus pins
    reg clk_s1_q;
    reg clk_s2_q;
    reg clk_s3_q;
    reg cmd_s1_q;
    reg cmd_s2_q;

    always @(posedge clk) begin
        if (rst) begin
            clk_s1_q <= 1'b0;
            clk_s2_q <= 1'b0;
            clk_s3_q <= 1'b0;
            cmd_s1_q <= 1'b1;
            cmd_s2_q <= 1'b1;
        end else begin
            clk_s1_q <= card_clk;
            clk_s2_q <= clk_s1_q;
            clk_s3_q <= clk_s2_q;
            cmd_s1_q <= cmd_in;
            cmd_s2_q <= cmd_s1_q;
        end
    end

    // host changes the line on falling edges, we sample on rising ones
    wire bus_rise = clk_s2_q & ~clk_s3_q;
    wire bus_fall = ~clk_s2_q & clk_s3_q;

    // state and datapath registers
    reg [2:0] state_q;
    reg [2:0] state_d;
    reg [5:0] bit_cnt_q;
    reg [5:0] bit_cnt_d;
    reg [46:0] rx_sh_q;
    reg [46:0] rx_sh_d;
    reg [39:0] tx_sh_q;
    reg [39:0] tx_sh_d;
    reg [2:0] wait_q;
    reg [2:0] wait_d;
    reg [1:0] gap_q;
    reg [1:0] gap_d;
    reg cmd_out_q;
    reg cmd_out_d;
    reg cmd_oe_q;
    reg cmd_oe_d;
    reg cmd_valid_q;
    reg cmd_valid_d;
    reg [5:0] cmd_index_q;
    reg [5:0] cmd_index_d;
    reg [31:0] cmd_arg_q;
    reg [31:0] cmd_arg_d;
    reg [31:0] status_q;
    reg [31:0] status_d;
    reg [31:0] flag_q;
    reg [31:0] flag_d;
    reg snap;
    reg crc_fail;
    reg [31:0] ev;

    wire [6:0] rx_crc;
    wire [6:0] tx_crc;

    // checksum over the first 40 bits of each frame
    csw_crc7 u_rx_crc (
        .clk(clk),
        .rst(rst),
        .clr(state_q == ST_IDLE),
        .en((state_q == ST_RECV) && bus_rise && (bit_cnt_q < `CSW_CRC_SPAN)),
        .din(cmd_s2_q),
        .crc(rx_crc)
    );

    csw_crc7 u_tx_crc (
        .clk(clk),
        .rst(rst),
        .clr(state_q != ST_SEND),
        .en((state_q == ST_SEND) && bus_fall && (bit_cnt_q < `CSW_CRC_SPAN)),
        .din(tx_sh_q[39]),
        .crc(tx_crc)
    );

    wire frame_ok = rx_sh_q[46] & rx_sh_q[0];
    wire crc_ok = (rx_crc == rx_sh_q[7:1]);
    wire task_query = (rx_sh_q[45:40] == `CSW_STATUS_QUERY) && rx_sh_q[8 + `CSW_TASK_SEL];

    // word as it would be sent now
    wire [31:0] word = (flag_q & `CSW_STORED_MASK)
        | ({31'h0, locked_flag} << `CSW_B_LOCKED)
        | {`CSW_LOW_PAD, lower_status};

    // events from card logic and from the receiver
    always @* begin
        ev = 32'h0;
        ev[`CSW_B_ARG_BOUNDS] = arg_bounds_err_set;
        ev[`CSW_B_ADDR_MISALIGN] = addr_misalign_err_set;
        ev[`CSW_B_BLK_SIZE] = blk_size_err_set;
        ev[`CSW_B_ERASE_ORDER] = erase_order_err_set;
        ev[`CSW_B_ERASE_SELECTION] = erase_selection_err_set;
        ev[`CSW_B_PROTECTED_WRITE] = protected_write_err_set;
        ev[`CSW_B_LOCK_FAIL] = lock_fail_err_set;
        ev[`CSW_B_CMD_CHECKSUM] = crc_fail;
        ev[`CSW_B_CMD_NOT_ALLOWED] = cmd_not_allowed_err_set;
        ev[`CSW_B_ECC_FAIL] = ecc_fail_err_set;
        ev[`CSW_B_CONTROLLER_INTERNAL] = controller_internal_err_set;
        ev[`CSW_B_GENERAL] = general_err_set;
        ev[`CSW_B_SPEC_DATA_OVERWRITE] = spec_data_overwrite_err_set;
        ev[`CSW_B_ERASE_SKIP] = erase_skip_err_set;
    end

    // sticky flags; an event in the clearing cycle survives
    always @* begin
        if (snap) begin
            flag_d = (flag_q & ~`CSW_STORED_MASK) | ev;
        end else begin
            flag_d = flag_q | ev;
        end
    end

    // frame sequencer
    always @* begin
        state_d = state_q;
        bit_cnt_d = bit_cnt_q;
        rx_sh_d = rx_sh_q;
        tx_sh_d = tx_sh_q;
        wait_d = wait_q;
        gap_d = gap_q;
        cmd_out_d = cmd_out_q;
        cmd_oe_d = cmd_oe_q;
        cmd_valid_d = 1'b0;
        cmd_index_d = cmd_index_q;
        cmd_arg_d = cmd_arg_q;
        status_d = status_q;
        snap = 1'b0;
        crc_fail = 1'b0;
        case (state_q)
            ST_IDLE: begin
                bit_cnt_d = 6'h01;
                if (bus_rise && !cmd_s2_q) begin
                    state_d = ST_RECV;
                end
            end
            ST_RECV: begin
                if (bus_rise) begin
                    rx_sh_d = {rx_sh_q[45:0], cmd_s2_q};
                    bit_cnt_d = bit_cnt_q + 6'h01;
                    if (bit_cnt_q == `CSW_FRAME_LAST) begin
                        state_d = ST_CHECK;
                    end
                end
            end
            ST_CHECK: begin
                state_d = ST_IDLE;
                if (frame_ok && crc_ok) begin
                    cmd_valid_d = 1'b1;
                    cmd_index_d = rx_sh_q[45:40];
                    cmd_arg_d = rx_sh_q[39:8];
                    wait_d = 3'h0;
                    // task status is served elsewhere
                    if (!task_query) begin
                        state_d = ST_EVAL;
                    end
                end else if (frame_ok) begin
                    // no reply now; shown with the next good command that gets a reply
                    crc_fail = 1'b1;
                end
            end
            ST_EVAL: begin
                // give card logic time to flag errors of this command
                wait_d = wait_q + 3'h1;
                if (wait_q == `CSW_EVAL_CYC - 3'h1) begin
                    snap = 1'b1;
                    status_d = word;
                    tx_sh_d = {`CSW_REPLY_HEAD, cmd_index_q, word};
                    gap_d = 2'h0;
                    bit_cnt_d = 6'h00;
                    state_d = ST_GAP;
                end
            end
            ST_GAP: begin
                if (bus_rise) begin
                    gap_d = gap_q + 2'h1;
                    if (gap_q == `CSW_NCR - 2'h1) begin
                        state_d = ST_SEND;
                    end
                end
            end
            ST_SEND: begin
                if (bus_fall) begin
                    bit_cnt_d = bit_cnt_q + 6'h01;
                    cmd_oe_d = 1'b1;
                    if (bit_cnt_q == `CSW_FRAME_END) begin
                        cmd_oe_d = 1'b0;
                        cmd_out_d = 1'b1;
                        bit_cnt_d = 6'h01;
                        state_d = ST_IDLE;
                    end else if (bit_cnt_q == `CSW_CRC_SPAN) begin
                        // checksum then end bit follow the word
                        cmd_out_d = tx_crc[6];
                        tx_sh_d = {tx_crc[5:0], 1'b1, 33'h0};
                    end else begin
                        cmd_out_d = tx_sh_q[39];
                        tx_sh_d = {tx_sh_q[38:0], 1'b0};
                    end
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always @(posedge clk) begin
        if (rst) begin
            state_q <= ST_IDLE;
            bit_cnt_q <= 6'h01;
            rx_sh_q <= 47'h0;
            tx_sh_q <= 40'h0;
            wait_q <= 3'h0;
            gap_q <= 2'h0;
            cmd_out_q <= 1'b1;
            cmd_oe_q <= 1'b0;
            cmd_valid_q <= 1'b0;
            cmd_index_q <= 6'h00;
            cmd_arg_q <= 32'h0;
            status_q <= 32'h0;
            flag_q <= 32'h0;
        end else begin
            state_q <= state_d;
            bit_cnt_q <= bit_cnt_d;
            rx_sh_q <= rx_sh_d;
            tx_sh_q <= tx_sh_d;
            wait_q <= wait_d;
            gap_q <= gap_d;
            cmd_out_q <= cmd_out_d;
            cmd_oe_q <= cmd_oe_d;
            cmd_valid_q <= cmd_valid_d;
            cmd_index_q <= cmd_index_d;
            cmd_arg_q <= cmd_arg_d;
            status_q <= status_d;
            flag_q <= flag_d;
        end
    end

    assign cmd_out = cmd_out_q;
    assign cmd_oe = cmd_oe_q;
    assign cmd_valid = cmd_valid_q;
    assign cmd_index = cmd_index_q;
    assign cmd_arg = cmd_arg_q;
    assign device_status_word = status_q;

endmodule

// *** csw_regs.vh ***
// constants for the device status word carried in the 48-bit normal reply
// assumes it is included by csw_status_word.v and csw_crc7.v only
//
// What this block does
// - status-query with arg bit 15 clear returns word
// - entries describe the command being answered; bit 23 the one before
// - reserved bits, including 18 and 17, read zero
// - response-detected bits set for current reply
// - execution-detected bits set while command runs
// - state-following bits mirror present card condition
// - previous-command bits clear one command later
// - bit 31 argument arg_bounds_err, clear-by-read
// - bit 30 misaligned address, clear-by-read
// - bit 29 block length or count error
// - bit 28 erase commands out of order
// - bit 27 invalid erase block selection
// - bit 26 write to protected block or card
// - bit 25 follows current lock condition
// - bit 24 lock or unlock sequence failure
// - bit 23 previous command checksum failed
// - bit 22 command illegal in current state
// - bit 21 internal correction failed
// - bit 20 controller error, bit 19 general error
// - bit 16 specific-data overwrite attempt or mismatch
// - bit 15 erase skipped protected blocks
// - word sits in reply bits 39 to 8

`ifndef CSW_REGS_VH
`define CSW_REGS_VH

// status word bit positions
`define CSW_B_ARG_BOUNDS 31
`define CSW_B_ADDR_MISALIGN 30
`define CSW_B_BLK_SIZE 29
`define CSW_B_ERASE_ORDER 28
`define CSW_B_ERASE_SELECTION 27
`define CSW_B_PROTECTED_WRITE 26
`define CSW_B_LOCKED 25
`define CSW_B_LOCK_FAIL 24
`define CSW_B_CMD_CHECKSUM 23
`define CSW_B_CMD_NOT_ALLOWED 22
`define CSW_B_ECC_FAIL 21
`define CSW_B_CONTROLLER_INTERNAL 20
`define CSW_B_GENERAL 19
`define CSW_B_SPEC_DATA_OVERWRITE 16
`define CSW_B_ERASE_SKIP 15

// bits held in the local flag register and cleared once reported
`define CSW_STORED_MASK 32'hfdf9_8000
// lower status bits supplied from outside
`define CSW_LOW_BITS 15
`define CSW_LOW_PAD 17'h0_0000

// frame layout and timing
`define CSW_FRAME_LAST 6'h2f
`define CSW_FRAME_END 6'h30
`define CSW_CRC_SPAN 6'h28
`define CSW_REPLY_HEAD 2'h0
`define CSW_STATUS_QUERY 6'h0d
`define CSW_TASK_SEL 15
`define CSW_NCR 2'h2
`define CSW_EVAL_CYC 3'h4
`define CSW_CRC_POLY 7'h09

`endif

// *** csw_crc7.v ***
// seven-bit checksum accumulator, one bit per enable
// assumes clr and en come from logic on the same clock
`timescale 1ns/1ps
`include "csw_regs.vh"

module csw_crc7 (
    // clock and reset
    input wire clk,
    input wire rst,
    // control
    input wire clr,
    input wire en,
    input wire din,
    // result
    output wire [6:0] crc
);

    reg [6:0] crc_q;
    wire fb = din ^ crc_q[6];

    always @(posedge clk) begin
        if (rst || clr) begin
            crc_q <= 7'h00;
        end else if (en) begin
            crc_q <= {crc_q[5:0], 1'b0} ^ (fb ? `CSW_CRC_POLY : 7'h00);
        end
    end

    assign crc = crc_q;

endmodule

// *** csw_host_model.sv ***
// host model on the card command bus: clocks frames out, collects replies
// assumes the line is pulled up while nobody drives it
`timescale 1ns/1ps
module csw_host_model (
    // card command bus
    output logic card_clk,
    output wire cmd_in,
    input wire cmd_out,
    input wire cmd_oe
);
    logic drv = 1'b0;
    logic hb = 1'b1;
    initial card_clk = 1'b0;
    assign cmd_in = cmd_oe ? cmd_out : (drv ? hb : 1'b1);

    function automatic logic [6:0] crc7(input logic [39:0] d);
        logic [6:0] c;
        c = 7'h00;
        for (int i = 39; i >= 0; i--) c = {c[5:0], 1'b0} ^ ((c[6] ^ d[i]) ? 7'h09 : 7'h00);
        return c;
    endfunction

    // clock stands low between frames; bad spoils the checksum
    task automatic xfer(input logic [5:0] idx, input logic [31:0] arg, input logic bad,
            output logic [47:0] r, output int n);
        logic [47:0] f;
        f = {2'h1, idx, arg, crc7({2'h1, idx, arg}) ^ {6'h00, bad}, 1'h1};
        n = 0;
        r = '1;
        #320 drv = 1'b1;
        for (int i = 47; i >= 0; i--) begin
            hb = f[i];
            #160 card_clk = 1'b1;
            #160 card_clk = 1'b0;
        end
        drv = 1'b0;
        for (int k = 0; k < 140 && n < 48; k++) begin
            #160 card_clk = 1'b1;
            if (n > 0 || cmd_in === 1'b0) begin
                r = {r[46:0], cmd_in};
                n++;
            end
            #160 card_clk = 1'b0;
        end
    endtask
endmodule

// *** csw_status_word_assertions.sv ***
// assertions on the status word block ports
// assumes one clock domain and a card clock of eight system clocks
`timescale 1ns/1ps
module csw_status_word_assertions (
    // clock and reset
    input wire clk,
    input wire rst,
    // command bus
    input wire cmd_out,
    input wire cmd_oe,
    input wire cmd_valid,
    input wire [5:0] cmd_index,
    input wire [31:0] cmd_arg,
    // card side
    input wire arg_bounds_err_set,
    input wire general_err_set,
    input wire locked_flag,
    input wire [14:0] lower_status,
    input wire [31:0] device_status_word
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    logic [9:0] oe_len_q;
    wire snap = cmd_valid && !(cmd_index == 6'h0d && cmd_arg[15]);
    always @(posedge clk) oe_len_q <= (rst || !cmd_oe) ? 10'h000 : oe_len_q + 10'h001;

    sequence s_bounds_ev;
        snap ##1 arg_bounds_err_set;
    endsequence
    sequence s_general_ev;
        snap ##2 general_err_set;
    endsequence
    property p_reserved_zero; device_status_word[18:17] == 2'h0; endproperty
    property p_snap_mirror; snap |-> ##4 device_status_word[25] == $past(locked_flag)
        && device_status_word[14:0] == $past(lower_status); endproperty
    property p_bounds_ev; s_bounds_ev |-> ##3 device_status_word[31]; endproperty
    property p_general_ev; s_general_ev |-> ##2 device_status_word[19]; endproperty
    property p_idle_high; !cmd_oe |-> cmd_out; endproperty
    property p_start_bit; $rose(cmd_oe) |-> !cmd_out; endproperty
    property p_quiet_on_valid; cmd_valid |-> !cmd_oe [*8]; endproperty
    property p_reply_start; snap |-> ##[8:60] $rose(cmd_oe); endproperty
    property p_reply_len; $fell(cmd_oe) |-> oe_len_q >= 10'h17e && oe_len_q <= 10'h182; endproperty

    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set");
    a_snap_mirror: assert property (p_snap_mirror) else $error("lock or low bits stale");
    a_bounds_ev: assert property (p_bounds_ev) else $error("bit 31 missing");
    a_general_ev: assert property (p_general_ev) else $error("bit 19 missing");
    a_idle_high: assert property (p_idle_high) else $error("line not idle high");
    a_start_bit: assert property (p_start_bit) else $error("no start bit");
    a_quiet_on_valid: assert property (p_quiet_on_valid) else $error("reply too early");
    a_reply_start: assert property (p_reply_start) else $error("no reply");
    a_reply_len: assert property (p_reply_len) else $error("reply length wrong");
endmodule

bind csw_status_word csw_status_word_assertions csw_chk (.clk(clk), .rst(rst), .cmd_out(cmd_out),
    .cmd_oe(cmd_oe), .cmd_valid(cmd_valid), .cmd_index(cmd_index), .cmd_arg(cmd_arg),
    .arg_bounds_err_set(arg_bounds_err_set), .general_err_set(general_err_set),
    .locked_flag(locked_flag), .lower_status(lower_status), .device_status_word(device_status_word));

// *** card_status_word_upper_bench.sv ***
// bench for the status word block with a host model on the command bus
// assumes the host model and the checker are compiled first
`timescale 1ns/1ps
module card_status_word_upper_bench;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [12:0] ev = 13'h0000;
    logic locked = 1'b0;
    logic [14:0] low = 15'h0000;
    wire card_clk, cmd_in, cmd_out, cmd_oe, cmd_valid;
    wire [5:0] cmd_index;
    wire [31:0] cmd_arg, dsw;
    int n_errors = 0;
    int checks_done = 0;
    int bp[13] = '{31, 30, 29, 28, 27, 26, 24, 22, 21, 20, 19, 16, 15};

    initial forever #20 clk = ~clk;

    csw_host_model csw_host_model_inst (.card_clk(card_clk), .cmd_in(cmd_in), .cmd_out(cmd_out),
        .cmd_oe(cmd_oe));
    csw_status_word csw_status_word_inst (.clk(clk), .rst(rst), .card_clk(card_clk), .cmd_in(cmd_in),
        .cmd_out(cmd_out), .cmd_oe(cmd_oe), .cmd_valid(cmd_valid), .cmd_index(cmd_index), .cmd_arg(cmd_arg),
        .arg_bounds_err_set(ev[0]), .addr_misalign_err_set(ev[1]), .blk_size_err_set(ev[2]),
        .erase_order_err_set(ev[3]), .erase_selection_err_set(ev[4]), .protected_write_err_set(ev[5]),
        .lock_fail_err_set(ev[6]), .cmd_not_allowed_err_set(ev[7]), .ecc_fail_err_set(ev[8]),
        .controller_internal_err_set(ev[9]), .general_err_set(ev[10]), .spec_data_overwrite_err_set(ev[11]),
        .erase_skip_err_set(ev[12]), .locked_flag(locked), .lower_status(low), .device_status_word(dsw));

    task automatic chk(input string what, input logic [47:0] seen, input logic [47:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic summarize;
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // expected word from present lock and low bits, plus one flag if b is not negative
    function automatic logic [31:0] exp_w(input int b);
        return {6'h00, locked, 10'h000, low} | (b >= 0 ? 32'h1 << b : 32'h0);
    endfunction

    task automatic query(input logic [31:0] w, input string what);
        logic [47:0] r;
        int n;
        @(posedge clk) #1;
        csw_host_model_inst.xfer(6'h0d, 32'h0, 1'b0, r, n);
        chk(what, r, {2'h0, 6'h0d, w, csw_host_model_inst.crc7({2'h0, 6'h0d, w}), 1'h1});
        chk("status copy", {16'h0000, dsw}, {16'h0000, w});
    endtask

    task automatic t_mirror;
        for (int i = 0; i < 2; i++) begin
            @(posedge clk) #1;
            locked = (i == 0);
            low = i ? 15'h25a5 : 15'h3a5a;
            query(exp_w(-1), "mirror");
        end
    endtask

    task automatic t_events;
        for (int i = 0; i < 13; i++) begin
            @(posedge clk) #1;
            ev[i] = 1'b1;
            @(posedge clk) #1;
            ev[i] = 1'b0;
            query(exp_w(bp[i]), "flag");
            query(exp_w(-1), "flag cleared");
        end
    endtask

    task automatic t_exec;
        fork
            query(exp_w(21) | exp_w(31) | exp_w(19), "flag in run");
            begin
                @(posedge clk iff cmd_valid === 1'b1);
                #1 ev[8] = 1'b1;
                ev[0] = 1'b1;
                @(posedge clk) #1;
                ev[8] = 1'b0;
                ev[0] = 1'b0;
                ev[10] = 1'b1;
                @(posedge clk) #1;
                ev[10] = 1'b0;
            end
        join
        query(exp_w(-1), "run flag cleared");
    endtask

    task automatic t_crc;
        logic [47:0] r;
        int n;
        @(posedge clk) #1;
        csw_host_model_inst.xfer(6'h0d, 32'h0, 1'b1, r, n);
        chk("bad frame reply", 48'(n), 48'h0);
        query(exp_w(23), "checksum flag");
        query(exp_w(-1), "checksum cleared");
    endtask

    task automatic t_task;
        logic [47:0] r;
        int n;
        @(posedge clk) #1;
        csw_host_model_inst.xfer(6'h0d, 32'h0000_8000, 1'b0, r, n);
        chk("task query reply", 48'(n), 48'h0);
        chk("task query taken", {10'h000, cmd_index, cmd_arg}, {10'h000, 6'h0d, 32'h0000_8000});
    endtask

    initial begin
        #3_000_000;
        n_errors++;
        summarize;
    end

    initial begin
        repeat (12) @(posedge clk);
        #1 rst = 1'b0;
        repeat (4) @(posedge clk);
        chk("reset state", {14'h0000, cmd_oe, cmd_out, dsw}, {14'h0000, 2'h1, 32'h0});
        t_mirror;
        t_events;
        t_exec;
        t_crc;
        t_task;
        summarize;
    end
endmodule
